/* verilog/rss_stage_timer.sv */
// Purpose: Shared constants of the rail start-up sequencer, and one delay/soft-start stage timer.
// Assumes: clk_sys at 50 MHz; rst synchronous, active high; trigger is synchronous to clk_sys.
// Notes:   The stage timer waits for its trigger, counts a delay, enables its rail, then counts the ramp.

package rss_pkg;
	// Clock and counter sizing
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned CNT_W          = 21;
	// Times in microseconds
	localparam int unsigned LINEAR_REGULATOR_TWO_DLY_US    = 500;
	localparam int unsigned LINEAR_REGULATOR_TWO_SS_US     = 275;
	localparam int unsigned B1_DLY_US      = 500;
	localparam int unsigned B1_SS_US       = 600;
	localparam int unsigned B2_DLY_US      = 500;
	localparam int unsigned B2_SS_US       = 600;
	localparam int unsigned B3_DLY_US      = 1000;
	localparam int unsigned B3_SS_US       = 600;
	localparam int unsigned SYSRST_DLY_US  = 20000;
	// Cycle counts derived from the times
	localparam int unsigned LINEAR_REGULATOR_TWO_DLY_CYC   = LINEAR_REGULATOR_TWO_DLY_US * CLK_MHZ;
	localparam int unsigned LINEAR_REGULATOR_TWO_SS_CYC    = LINEAR_REGULATOR_TWO_SS_US * CLK_MHZ;
	localparam int unsigned B1_DLY_CYC     = B1_DLY_US * CLK_MHZ;
	localparam int unsigned B1_SS_CYC      = B1_SS_US * CLK_MHZ;
	localparam int unsigned B2_DLY_CYC     = B2_DLY_US * CLK_MHZ;
	localparam int unsigned B2_SS_CYC      = B2_SS_US * CLK_MHZ;
	localparam int unsigned B3_DLY_CYC     = B3_DLY_US * CLK_MHZ;
	localparam int unsigned B3_SS_CYC      = B3_SS_US * CLK_MHZ;
	localparam int unsigned SYSRST_DLY_CYC = SYSRST_DLY_US * CLK_MHZ;
	// Register port
	localparam int unsigned ADDR_W         = 4;
	localparam int unsigned DATA_W         = 8;
	localparam logic [3:0] REG_SLEEP       = 4'h0;
	localparam logic [3:0] REG_DEEP_SLEEP  = 4'h1;
	localparam logic [3:0] REG_B1_PRIMARY_VOLTAGE_SETPOINT    = 4'h2;
	localparam logic [3:0] REG_B1_ALTERNATE_VOLTAGE_SETPOINT    = 4'h3;
	localparam logic [3:0] REG_B3_PRIMARY_VOLTAGE_SETPOINT    = 4'h4;
	localparam logic [3:0] REG_B3_ALTERNATE_VOLTAGE_SETPOINT    = 4'h5;
	localparam logic [3:0] REG_STATUS      = 4'h6;
	localparam logic [3:0] REG_BUS_ADDR    = 4'h7;
	// Sleep field positions
	localparam int unsigned SLP_MODE_BIT   = 0;
	localparam int unsigned SLP_EN_BIT     = 1;
	localparam int unsigned SLP_REQ_BIT    = 2;
	localparam logic [2:0] SLEEP_RST       = 3'h0;
	localparam logic [2:0] DEEP_SLEEP_RST  = 3'h1;
	// Serial management address and its address bytes
	localparam logic [6:0] MGMT_ADDR7      = 7'h25;
	localparam logic [7:0] MGMT_WR_BYTE    = 8'h4A;
	localparam logic [7:0] MGMT_RD_BYTE    = 8'h4B;
	// Step-down rail one setpoint mapping, microvolts
	localparam logic [21:0] B1_REF_UV      = 22'h0C3500;
	localparam logic [13:0] B1_STEP_UV     = 14'h30D4;
	// Setpoint reset codes (0.8 V base, 12.5 mV steps)
	localparam logic [7:0] B1_VSET_CFG1    = 8'h14;
	localparam logic [7:0] B1_VSET_CFG2    = 8'h08;
	localparam logic [7:0] B3_PRIMARY_VOLTAGE_SETPOINT_RST    = 8'h38;
	localparam logic [7:0] B3_ALTERNATE_VOLTAGE_SETPOINT_RST    = 8'h2C;
	localparam logic [7:0] B3_VSET_CFG2    = 8'h20;
	typedef enum logic [1:0] {RSS_IDLE, RSS_DELAY, RSS_RAMP, RSS_DONE} rss_stage_e;
endpackage

module rss_stage_timer #(
	parameter int unsigned W = rss_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Control
	input  wire logic         clear,
	input  wire logic         trigger,
	input  wire logic [W-1:0] delay_cycles,
	input  wire logic [W-1:0] ramp_cycles,
	// Status
	output logic              enable_r,
	output logic              ramp_done_r
);
	rss_pkg::rss_stage_e state_r;
	logic [W-1:0]        cnt_r;
	wire                 delay_end = (cnt_r == delay_cycles - W'(1));
	wire                 ramp_end  = (cnt_r == ramp_cycles - W'(1));

	always_ff @(posedge clk_sys)
	begin
		if (rst || clear)
		begin
			state_r     <= rss_pkg::RSS_IDLE;
			cnt_r       <= '0;
			enable_r    <= 1'b0;
			ramp_done_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				rss_pkg::RSS_IDLE:
				begin
					cnt_r <= '0;
					if (trigger)
						state_r <= rss_pkg::RSS_DELAY;
				end
				rss_pkg::RSS_DELAY:
				begin
					cnt_r <= delay_end ? '0 : cnt_r + W'(1);
					if (delay_end)
					begin
						enable_r <= 1'b1;
						state_r  <= rss_pkg::RSS_RAMP;
					end
				end
				rss_pkg::RSS_RAMP:
				begin
					cnt_r <= cnt_r + W'(1);
					if (ramp_end)
					begin
						ramp_done_r <= 1'b1;
						state_r     <= rss_pkg::RSS_DONE;
					end
				end
				rss_pkg::RSS_DONE:
					cnt_r <= '0;
			endcase
		end
	end
endmodule

/* verilog/rss_sequencer.sv */
// Purpose: Start-up chain, open-drain pin control, voltage select and sleep bits of a multi-rail power manager.
// Assumes: All inputs synchronous to clk_sys; rail power-good inputs come from the converter monitors.
// Notes:   CONFIG 1 is the first factory setup, CONFIG 2 the second; long counts are shortenable parameters.
//
// Decided for this implementation: the strobed register port and the register offsets.

// Contract
// - Linear regulator two first: 500us, 275us ramp
// - Step-down one after regulator two: 500/600us
// - Step-down two after step-down one: 500us
// - Setup one: step-down three 1000us after two
// - Setup two: step-down three 1000us after two
// - Supply enable released when step-down two good
// - System reset released 20ms after regulator two
// - Interrupt pin is active-low open drain
// - Setup one: select high 1.5V, low 1.35V
// - Voltage select may change; setpoint follows
// - Management address 0x25, bytes 0x4A/0x4B
// - Sleep select, enable, request reset to 0
// - Deep-sleep select resets 1, others 0
// - Step-down one: 0.8V plus 12.5mV steps
// - Alternate select uses alternate setpoint registers
module rss_sequencer #(
	parameter int unsigned CONFIG         = 1,
	parameter int unsigned LINEAR_REGULATOR_TWO_DLY_CYC   = rss_pkg::LINEAR_REGULATOR_TWO_DLY_CYC,
	parameter int unsigned LINEAR_REGULATOR_TWO_SS_CYC    = rss_pkg::LINEAR_REGULATOR_TWO_SS_CYC,
	parameter int unsigned B1_DLY_CYC     = rss_pkg::B1_DLY_CYC,
	parameter int unsigned B1_SS_CYC      = rss_pkg::B1_SS_CYC,
	parameter int unsigned B2_DLY_CYC     = rss_pkg::B2_DLY_CYC,
	parameter int unsigned B2_SS_CYC      = rss_pkg::B2_SS_CYC,
	parameter int unsigned B3_DLY_CYC     = rss_pkg::B3_DLY_CYC,
	parameter int unsigned B3_SS_CYC      = rss_pkg::B3_SS_CYC,
	parameter int unsigned SYSRST_DLY_CYC = rss_pkg::SYSRST_DLY_CYC
) (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	// Input supply monitor
	input  wire logic                        input_undervoltage_lockout,
	// Rail power-good monitors
	input  wire logic                        linear_regulator_two_pg,
	input  wire logic                        step_down_rail_one_pg,
	input  wire logic                        step_down_rail_two_pg,
	input  wire logic                        step_down_rail_three_pg,
	// Rail enables and soft-start status
	output logic                             linear_regulator_two_en,
	output logic                             step_down_rail_one_en,
	output logic                             step_down_rail_two_en,
	output logic                             step_down_rail_three_en,
	output logic                             linear_regulator_two_ramp_done,
	output logic                             step_down_rail_one_ramp_done,
	output logic                             step_down_rail_two_ramp_done,
	output logic                             step_down_rail_three_ramp_done,
	// System reset pin, open drain
	input  wire logic                        system_reset_out_n_i,
	output logic                             system_reset_out_n_o,
	output logic                             system_reset_out_n_oe_n,
	// External supply enable pin, open drain
	input  wire logic                        external_supply_enable_i,
	output logic                             external_supply_enable_o,
	output logic                             external_supply_enable_oe_n,
	// Interrupt pin, open drain
	input  wire logic                        irq_event,
	input  wire logic                        interrupt_request_n_i,
	output logic                             interrupt_request_n_o,
	output logic                             interrupt_request_n_oe_n,
	// Voltage select pin
	input  wire logic                        voltage_select_input,
	// Setpoints in use
	output logic [7:0]                       step_down_rail_one_code_r,
	output logic [7:0]                       step_down_rail_three_code_r,
	output logic [21:0]                      step_down_rail_one_uv_r,
	output logic                             alternate_setpoint_active_r,
	// Sleep controls
	output logic [2:0]                       sleep_ctrl_r,
	output logic [2:0]                       deep_sleep_ctrl_r,
	// Register port
	input  wire logic [rss_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [rss_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [rss_pkg::DATA_W-1:0]       reg_rdata_r
);
	localparam int unsigned W = rss_pkg::CNT_W;

	// Configuration dependent defaults
	localparam logic [7:0] B1_VSET_RST = (CONFIG == 1) ? rss_pkg::B1_VSET_CFG1 : rss_pkg::B1_VSET_CFG2;
	localparam logic [7:0] B3_V0_RST   = (CONFIG == 1) ? rss_pkg::B3_PRIMARY_VOLTAGE_SETPOINT_RST : rss_pkg::B3_VSET_CFG2;
	localparam logic [7:0] B3_V1_RST   = (CONFIG == 1) ? rss_pkg::B3_ALTERNATE_VOLTAGE_SETPOINT_RST : rss_pkg::B3_VSET_CFG2;

	// Setpoint registers and registered pin states
	logic [7:0] b1_primary_voltage_setpoint_r;
	logic [7:0] b1_alternate_voltage_setpoint_r;
	logic [7:0] b3_primary_voltage_setpoint_r;
	logic [7:0] b3_alternate_voltage_setpoint_r;
	logic       vsel_r;
	logic       irq_r;
	logic       external_supply_enable_r;
	logic       sysrst_rel_r;

	// Chain state
	wire        lockout = input_undervoltage_lockout;
	wire        chain_clear = lockout;
	wire        chain_start = ~lockout;
	wire        sysrst_rel;

	// Rail enable chain
	rss_stage_timer #(.W(W)) u_linear_regulator_two (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.clear        (chain_clear),
		.trigger      (chain_start),
		.delay_cycles (W'(LINEAR_REGULATOR_TWO_DLY_CYC)),
		.ramp_cycles  (W'(LINEAR_REGULATOR_TWO_SS_CYC)),
		.enable_r     (linear_regulator_two_en),
		.ramp_done_r  (linear_regulator_two_ramp_done)
	);

	rss_stage_timer #(.W(W)) u_b1 (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.clear        (chain_clear),
		.trigger      (linear_regulator_two_pg & linear_regulator_two_en),
		.delay_cycles (W'(B1_DLY_CYC)),
		.ramp_cycles  (W'(B1_SS_CYC)),
		.enable_r     (step_down_rail_one_en),
		.ramp_done_r  (step_down_rail_one_ramp_done)
	);

	rss_stage_timer #(.W(W)) u_b2 (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.clear        (chain_clear),
		.trigger      (step_down_rail_one_pg & step_down_rail_one_en),
		.delay_cycles (W'(B2_DLY_CYC)),
		.ramp_cycles  (W'(B2_SS_CYC)),
		.enable_r     (step_down_rail_two_en),
		.ramp_done_r  (step_down_rail_two_ramp_done)
	);

	// Same timing and same trigger, step-down two good, in both setups
	rss_stage_timer #(.W(W)) u_b3 (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.clear        (chain_clear),
		.trigger      (step_down_rail_two_pg & step_down_rail_two_en),
		.delay_cycles (W'(B3_DLY_CYC)),
		.ramp_cycles  (W'(B3_SS_CYC)),
		.enable_r     (step_down_rail_three_en),
		.ramp_done_r  (step_down_rail_three_ramp_done)
	);

	// System reset release timer, one-cycle ramp unused
	rss_stage_timer #(.W(W)) u_sysrst (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.clear        (chain_clear),
		.trigger      (linear_regulator_two_pg & linear_regulator_two_en),
		.delay_cycles (W'(SYSRST_DLY_CYC)),
		.ramp_cycles  (W'(1)),
		.enable_r     (sysrst_rel),
		.ramp_done_r  ()
	);

	// Register decode
	wire wr_sleep = reg_wr && (reg_addr == rss_pkg::REG_SLEEP);
	wire wr_dslp  = reg_wr && (reg_addr == rss_pkg::REG_DEEP_SLEEP);
	wire wr_b1v0  = reg_wr && (reg_addr == rss_pkg::REG_B1_PRIMARY_VOLTAGE_SETPOINT);
	wire wr_b1v1  = reg_wr && (reg_addr == rss_pkg::REG_B1_ALTERNATE_VOLTAGE_SETPOINT);
	wire wr_b3v0  = reg_wr && (reg_addr == rss_pkg::REG_B3_PRIMARY_VOLTAGE_SETPOINT);
	wire wr_b3v1  = reg_wr && (reg_addr == rss_pkg::REG_B3_ALTERNATE_VOLTAGE_SETPOINT);

	// Alternate state is voltage select low; setup two has no select pin function
	wire        use_alt  = (CONFIG == 1) && !vsel_r;
	wire [7:0]  b1_code  = use_alt ? b1_alternate_voltage_setpoint_r : b1_primary_voltage_setpoint_r;
	wire [7:0]  b3_code  = use_alt ? b3_alternate_voltage_setpoint_r : b3_primary_voltage_setpoint_r;
	// Product widened before multiplying so the top codes keep their upper bits
	wire [21:0] b1_uv    = rss_pkg::B1_REF_UV + 22'(b1_code) * 22'(rss_pkg::B1_STEP_UV);

	wire [7:0]  status_word = {
		sysrst_rel_r,
		external_supply_enable_r,
		vsel_r,
		system_reset_out_n_i,
		external_supply_enable_i,
		interrupt_request_n_i,
		step_down_rail_three_en,
		step_down_rail_two_en
	};

	logic [7:0] rd_mux;
	always_comb
	begin
		unique case (reg_addr)
			rss_pkg::REG_SLEEP:      rd_mux = {5'h00, sleep_ctrl_r};
			rss_pkg::REG_DEEP_SLEEP: rd_mux = {5'h00, deep_sleep_ctrl_r};
			rss_pkg::REG_B1_PRIMARY_VOLTAGE_SETPOINT:   rd_mux = b1_primary_voltage_setpoint_r;
			rss_pkg::REG_B1_ALTERNATE_VOLTAGE_SETPOINT:   rd_mux = b1_alternate_voltage_setpoint_r;
			rss_pkg::REG_B3_PRIMARY_VOLTAGE_SETPOINT:   rd_mux = b3_primary_voltage_setpoint_r;
			rss_pkg::REG_B3_ALTERNATE_VOLTAGE_SETPOINT:   rd_mux = b3_alternate_voltage_setpoint_r;
			rss_pkg::REG_STATUS:     rd_mux = status_word;
			rss_pkg::REG_BUS_ADDR:   rd_mux = {1'b0, rss_pkg::MGMT_ADDR7};
			default:                 rd_mux = 8'h00;
		endcase
	end

	// Software registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sleep_ctrl_r      <= rss_pkg::SLEEP_RST;
			deep_sleep_ctrl_r <= rss_pkg::DEEP_SLEEP_RST;
			b1_primary_voltage_setpoint_r        <= B1_VSET_RST;
			b1_alternate_voltage_setpoint_r        <= B1_VSET_RST;
			b3_primary_voltage_setpoint_r        <= B3_V0_RST;
			b3_alternate_voltage_setpoint_r        <= B3_V1_RST;
			reg_rdata_r       <= 8'h00;
		end
		else
		begin
			if (wr_sleep)
				sleep_ctrl_r <= reg_wdata[2:0];
			if (wr_dslp)
				deep_sleep_ctrl_r <= reg_wdata[2:0];
			if (wr_b1v0)
				b1_primary_voltage_setpoint_r <= reg_wdata;
			if (wr_b1v1)
				b1_alternate_voltage_setpoint_r <= reg_wdata;
			if (wr_b3v0)
				b3_primary_voltage_setpoint_r <= reg_wdata;
			if (wr_b3v1)
				b3_alternate_voltage_setpoint_r <= reg_wdata;
			reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Pin sampling and setpoint outputs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			vsel_r                      <= 1'b1;
			irq_r                       <= 1'b0;
			step_down_rail_one_code_r   <= B1_VSET_RST;
			step_down_rail_three_code_r <= B3_V0_RST;
			step_down_rail_one_uv_r     <= 22'h000000;
			alternate_setpoint_active_r <= 1'b0;
		end
		else
		begin
			vsel_r                      <= voltage_select_input;
			irq_r                       <= irq_event;
			step_down_rail_one_code_r   <= b1_code;
			step_down_rail_three_code_r <= b3_code;
			step_down_rail_one_uv_r     <= b1_uv;
			alternate_setpoint_active_r <= use_alt;
		end
	end

	// Open-drain pins: output always low, enable low only while pulling down
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			external_supply_enable_r                    <= 1'b0;
			sysrst_rel_r                <= 1'b0;
			system_reset_out_n_o        <= 1'b0;
			system_reset_out_n_oe_n     <= 1'b0;
			external_supply_enable_o    <= 1'b0;
			external_supply_enable_oe_n <= 1'b0;
			interrupt_request_n_o       <= 1'b0;
			interrupt_request_n_oe_n    <= 1'b1;
		end
		else
		begin
			external_supply_enable_r                    <= step_down_rail_two_pg & step_down_rail_two_en & ~lockout;
			sysrst_rel_r                <= sysrst_rel & ~lockout;
			system_reset_out_n_o        <= 1'b0;
			system_reset_out_n_oe_n     <= sysrst_rel & ~lockout;
			external_supply_enable_o    <= 1'b0;
			external_supply_enable_oe_n <= step_down_rail_two_pg & step_down_rail_two_en & ~lockout;
			interrupt_request_n_o       <= 1'b0;
			interrupt_request_n_oe_n    <= ~irq_event;
		end
	end
endmodule

/* sim/rss_sequencer_props.sv */
// Purpose: Port-level timing and value checks of the rail start-up sequencer.
// Assumes: Bound into rss_sequencer; its counts are handed on through the bind.
// Notes:   Stage timing is measured from the edge at which each trigger is first seen.
module rss_sequencer_props #(
	parameter int unsigned CONFIG         = 1,
	parameter int unsigned LINEAR_REGULATOR_TWO_DLY_CYC   = 10,
	parameter int unsigned LINEAR_REGULATOR_TWO_SS_CYC    = 6,
	parameter int unsigned B1_DLY_CYC     = 10,
	parameter int unsigned B1_SS_CYC      = 8,
	parameter int unsigned B2_DLY_CYC     = 10,
	parameter int unsigned B3_DLY_CYC     = 20,
	parameter int unsigned SYSRST_DLY_CYC = 50
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Supply and rail monitors
	input wire logic input_undervoltage_lockout,
	input wire logic linear_regulator_two_pg,
	input wire logic step_down_rail_one_pg,
	input wire logic step_down_rail_two_pg,
	// Rail controls
	input wire logic linear_regulator_two_en,
	input wire logic step_down_rail_one_en,
	input wire logic step_down_rail_two_en,
	input wire logic step_down_rail_three_en,
	input wire logic linear_regulator_two_ramp_done,
	input wire logic step_down_rail_one_ramp_done,
	// Pins
	input wire logic system_reset_out_n_oe_n,
	input wire logic external_supply_enable_oe_n,
	input wire logic irq_event,
	input wire logic interrupt_request_n_o,
	input wire logic interrupt_request_n_oe_n,
	input wire logic voltage_select_input,
	// Settings and registers
	input wire logic alternate_setpoint_active_r,
	input wire logic [2:0] sleep_ctrl_r,
	input wire logic [2:0] deep_sleep_ctrl_r,
	input wire logic [rss_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [rss_pkg::DATA_W-1:0] reg_rdata_r
);
	localparam int L1 = LINEAR_REGULATOR_TWO_DLY_CYC;
	localparam int L2 = LINEAR_REGULATOR_TWO_SS_CYC - 1;
	localparam int D1 = B1_DLY_CYC;
	localparam int R1 = B1_SS_CYC - 1;
	localparam int D2 = B2_DLY_CYC;
	localparam int D3 = B3_DLY_CYC;
	localparam int SR = SYSRST_DLY_CYC + 1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_linear_regulator_two_start_delay: assert property ($fell(input_undervoltage_lockout) |-> ##L1 !linear_regulator_two_en ##1 linear_regulator_two_en)
		else $error("regulator two enabled at wrong time");
	a_linear_regulator_two_ramp_count: assert property ($rose(linear_regulator_two_en) |-> ##L2 !linear_regulator_two_ramp_done ##1 linear_regulator_two_ramp_done)
		else $error("regulator two ramp wrong length");
	a_rail_one_delay: assert property ($rose(linear_regulator_two_pg && linear_regulator_two_en) |-> ##D1 !step_down_rail_one_en ##1 step_down_rail_one_en)
		else $error("rail one enabled at wrong time");
	a_rail_one_ramp: assert property ($rose(step_down_rail_one_en) |-> ##R1 !step_down_rail_one_ramp_done ##1 step_down_rail_one_ramp_done)
		else $error("rail one ramp wrong length");
	a_rail_two_delay: assert property ($rose(step_down_rail_one_pg && step_down_rail_one_en) |-> ##D2 !step_down_rail_two_en ##1 step_down_rail_two_en)
		else $error("rail two enabled at wrong time");
	a_rail_three_delay: assert property ($rose(step_down_rail_two_pg && step_down_rail_two_en) |-> ##D3 !step_down_rail_three_en ##1 step_down_rail_three_en)
		else $error("rail three enabled at wrong time");
	a_supply_en_release: assert property ($rose(step_down_rail_two_pg && step_down_rail_two_en) |=> external_supply_enable_oe_n)
		else $error("supply enable not released");
	a_supply_en_cause: assert property ($rose(external_supply_enable_oe_n) |-> $past(step_down_rail_two_pg && step_down_rail_two_en))
		else $error("supply enable released early");
	a_reset_pin_release: assert property ($rose(linear_regulator_two_pg && linear_regulator_two_en) |-> ##SR !system_reset_out_n_oe_n ##1 system_reset_out_n_oe_n)
		else $error("reset pin released at wrong time");
	a_irq_open_drain: assert property (1 |=> !interrupt_request_n_o && interrupt_request_n_oe_n == !$past(irq_event))
		else $error("interrupt pin wrong");
	a_select_follows: assert property (1 |=> alternate_setpoint_active_r == ((CONFIG == 1) && !$past(voltage_select_input, 2)))
		else $error("setpoint select not followed");
	a_lockout_clears: assert property (input_undervoltage_lockout |=> !linear_regulator_two_en && !step_down_rail_one_en
		&& !step_down_rail_two_en && !step_down_rail_three_en && !system_reset_out_n_oe_n && !external_supply_enable_oe_n)
		else $error("lockout did not clear chain");
	a_sleep_reset_value: assert property ($fell(rst) |-> sleep_ctrl_r == 3'h0 && deep_sleep_ctrl_r == 3'h1)
		else $error("sleep bits wrong after reset");
	a_address_read: assert property ($past(reg_rd) && $past(reg_addr) == 4'h7 |-> reg_rdata_r == 8'h25)
		else $error("bus address reads wrong");
endmodule

bind rss_sequencer rss_sequencer_props #(
	.CONFIG(CONFIG),
	.LINEAR_REGULATOR_TWO_DLY_CYC(LINEAR_REGULATOR_TWO_DLY_CYC),
	.LINEAR_REGULATOR_TWO_SS_CYC(LINEAR_REGULATOR_TWO_SS_CYC),
	.B1_DLY_CYC(B1_DLY_CYC),
	.B1_SS_CYC(B1_SS_CYC),
	.B2_DLY_CYC(B2_DLY_CYC),
	.B3_DLY_CYC(B3_DLY_CYC),
	.SYSRST_DLY_CYC(SYSRST_DLY_CYC)
) i_props (.*);

/* sim/rss_rail_model.sv */
// Purpose: Rails, monitors and pulled-up open-drain pins around the sequencer.
// Assumes: A rail is in regulation one cycle after its enable and ramp are both done.
// Notes:   Stall holds a rail out of regulation to play a slow converter.
module rss_rail_model (
	// Clock
	input wire logic clk_sys,
	// Rail controls
	input wire logic [3:0] rail_en,
	input wire logic [3:0] rail_done,
	input wire logic [3:0] stall,
	// Pin drives
	input wire logic sr_o,
	input wire logic sr_oe_n,
	input wire logic ext_o,
	input wire logic ext_oe_n,
	input wire logic irq_o,
	input wire logic irq_oe_n,
	// Monitors and pin levels
	output logic [3:0] rail_pg,
	output wire logic sr_pin,
	output wire logic ext_pin,
	output wire logic irq_pin
);
	always_ff @(posedge clk_sys)
		rail_pg <= rail_en & rail_done & ~stall;
	// Board pull-ups: a released pin reads high
	assign sr_pin = sr_oe_n ? 1'b1 : sr_o;
	assign ext_pin = ext_oe_n ? 1'b1 : ext_o;
	assign irq_pin = irq_oe_n ? 1'b1 : irq_o;
endmodule

/* sim/rss_sequencer_bench.sv */
// Purpose: Self-checking bench of the rail start-up sequencer.
// Assumes: Shortened delay counts; setup one.
// Notes:   Counts start at the first edge after the edge that launches a stimulus change.
`define CHK(a, b) \
	begin \
		compares++; \
		if ((a) !== (b)) \
		begin \
			errors++; \
			$display("wrong value at %0t: got %0h want %0h", $time, a, b); \
		end \
	end
module rss_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LD = 10;
	localparam int LS = 6;
	localparam int SR = 50;
	localparam int DL = 10;
	localparam int SS = 8;
	localparam int D3 = 20;
	logic clk_sys, rst, input_undervoltage_lockout, irq_event, voltage_select_input, reg_wr, reg_rd;
	logic [3:0] reg_addr, stall;
	logic [7:0] reg_wdata;
	wire linear_regulator_two_pg, step_down_rail_one_pg, step_down_rail_two_pg, step_down_rail_three_pg;
	wire linear_regulator_two_en, step_down_rail_one_en, step_down_rail_two_en, step_down_rail_three_en;
	wire linear_regulator_two_ramp_done, step_down_rail_one_ramp_done, step_down_rail_two_ramp_done;
	wire step_down_rail_three_ramp_done, system_reset_out_n_i, system_reset_out_n_o, system_reset_out_n_oe_n;
	wire external_supply_enable_i, external_supply_enable_o, external_supply_enable_oe_n;
	wire interrupt_request_n_i, interrupt_request_n_o, interrupt_request_n_oe_n, alternate_setpoint_active_r;
	wire [7:0] step_down_rail_one_code_r, step_down_rail_three_code_r, reg_rdata_r;
	wire [21:0] step_down_rail_one_uv_r;
	wire [2:0] sleep_ctrl_r, deep_sleep_ctrl_r;
	wire [5:0] mon = {external_supply_enable_i, system_reset_out_n_i, step_down_rail_three_en,
		step_down_rail_two_en, step_down_rail_one_en, linear_regulator_two_en};
	int errors, compares, cyc, n, m;

	rss_sequencer #(.CONFIG(1), .LINEAR_REGULATOR_TWO_DLY_CYC(LD), .LINEAR_REGULATOR_TWO_SS_CYC(LS), .B1_DLY_CYC(DL), .B1_SS_CYC(SS),
		.B2_DLY_CYC(DL), .B2_SS_CYC(SS), .B3_DLY_CYC(D3), .B3_SS_CYC(SS), .SYSRST_DLY_CYC(SR)) i_dut (.*);

	rss_rail_model i_rails (
		.clk_sys(clk_sys),
		.rail_en({step_down_rail_three_en, step_down_rail_two_en, step_down_rail_one_en, linear_regulator_two_en}),
		.rail_done({step_down_rail_three_ramp_done, step_down_rail_two_ramp_done, step_down_rail_one_ramp_done,
			linear_regulator_two_ramp_done}),
		.stall(stall),
		.sr_o(system_reset_out_n_o),
		.sr_oe_n(system_reset_out_n_oe_n),
		.ext_o(external_supply_enable_o),
		.ext_oe_n(external_supply_enable_oe_n),
		.irq_o(interrupt_request_n_o),
		.irq_oe_n(interrupt_request_n_oe_n),
		.rail_pg({step_down_rail_three_pg, step_down_rail_two_pg, step_down_rail_one_pg, linear_regulator_two_pg}),
		.sr_pin(system_reset_out_n_i),
		.ext_pin(external_supply_enable_i),
		.irq_pin(interrupt_request_n_i)
	);

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata_r, e)
	endtask
	// Counts edges until one monitored output is high, bounded
	task automatic wait_hi(input int i, output int k);
		k = 0;
		do
		begin
			@(posedge clk_sys);
			#1 k++;
		end while (mon[i] !== 1'b1 && k < 400);
	endtask
	task close_out;
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			errors++;
			close_out;
		end
	end

	initial
	begin
		{rst, input_undervoltage_lockout, voltage_select_input} = 3'h7;
		{irq_event, reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0;
		stall = 4'h4;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		tick(1);
		`CHK(mon[5:4], 2'h0)
		`CHK(interrupt_request_n_i, 1'b1)
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h01);
		rd(4'h7, 8'h25);
		wr(4'h7, 8'h00);
		rd(4'h7, 8'h25);
		rd(4'h9, 8'h00);
		wr(4'h0, 8'h07);
		rd(4'h0, 8'h07);
		wr(4'h0, 8'h00);
		// Start-up chain with rail two held out of regulation
		@(posedge clk_sys);
		input_undervoltage_lockout <= 1'b0;
		wait_hi(0, n);
		`CHK(n, LD + 1)
		wait_hi(4, m);
		`CHK(n + m, LD + LS + SR + 4)
		`CHK(mon[5:1], 5'h0B)
		tick(20);
		`CHK(mon[5:3], 3'h2)
		@(posedge clk_sys);
		stall <= 4'h0;
		wait_hi(5, n);
		`CHK(n, 2)
		wait_hi(3, n);
		`CHK(n, 20)
		// Setpoint selection, board strap driven by the bench
		tick(3);
		`CHK(step_down_rail_three_code_r, 8'h38)
		@(posedge clk_sys);
		voltage_select_input <= 1'b0;
		tick(3);
		`CHK(step_down_rail_three_code_r, 8'h2C)
		wr(4'h3, 8'hFF);
		tick(3);
		`CHK(step_down_rail_one_code_r, 8'hFF)
		`CHK(step_down_rail_one_uv_r, 22'h0C3500 + 22'h30D4 * 22'h0000FF)
		wr(4'h2, 8'h00);
		voltage_select_input <= 1'b1;
		tick(3);
		`CHK(step_down_rail_one_uv_r, 22'h0C3500)
		// Interrupt pin
		@(posedge clk_sys);
		irq_event <= 1'b1;
		tick(2);
		`CHK(interrupt_request_n_i, 1'b0)
		@(posedge clk_sys);
		irq_event <= 1'b0;
		tick(2);
		`CHK(interrupt_request_n_i, 1'b1)
		// Lockout in mid-run, then a restart checked up to regulator two enable
		@(posedge clk_sys);
		input_undervoltage_lockout <= 1'b1;
		tick(2);
		`CHK(mon, 6'h00)
		@(posedge clk_sys);
		input_undervoltage_lockout <= 1'b0;
		wait_hi(0, n);
		`CHK(n, LD + 1)
		close_out;
	end
endmodule
